// >>> bench/alrm_host.sv
// Purpose: host model that drives frames on the serial link of the limit bank
// Assumes: sclk idles low outside frames, 30 ns period
// Notes: sdo is taken at rising sclk, half a period after the bank moved it
`timescale 1ns/100ps
`default_nettype none

module alrm_host (
	output var  logic sclk,
	output var  logic cs_b,
	output var  logic sdi,
	input  wire logic sdo
);
	// idle link: deselected, clock still
	initial begin
		sclk = 1'b0;
		cs_b = 1'b1;
		sdi  = 1'b0;
	end

	// one frame of n cycles; r gathers sdo at rising edges 17 to 25
	task automatic frame(input logic [15:0] w, input int n, output logic [8:0] r);
		r = 9'h000;
		#7 cs_b = 1'b0;
		for (int i = 0; i < n; i++) begin
			#8 sdi = (i < 16) ? w[15-i] : ~sdi; // keep sdi moving once it is don't care
			#7 sclk = 1'b1;
			if (i >= 16 && i < 25)
				r[24-i] = sdo;
			#15 sclk = 1'b0;
		end
		#15 cs_b = 1'b1; // a read-back may stop after 24 cycles
		sdi = ~sdi;
		#150; // gap lets the bank execute and resnapshot
	endtask
endmodule
`default_nettype wire

// >>> bench/alrm_regs_tb_top.sv
// Purpose: self-checking bench for the low-limit bank and command echo
// Assumes: model of limits and echo kept in integers beside the design
// Notes: link clock comes from the host model, unrelated in phase to clk
`timescale 1ns/100ps
`default_nettype none

module alrm_regs_tb_top import alrm_pkg::*;;
	logic         clk, rst_b, ce, sclk, cs_b, sdi, result_valid, sdo;
	alrm_result_t result;
	logic [7:0]   low_alarm;
	logic [8:0]   r;
	int           num_errors, n_compared, echo, e;
	int           lim[8];
	int           al[8];

	alrm_regs #(.N_CH(8)) i_alrm_regs (.clk(clk), .rst_b(rst_b), .ce(ce), .sclk(sclk),
		.cs_b(cs_b), .sdi(sdi), .result_valid(result_valid), .result(result), .sdo(sdo),
		.low_alarm(low_alarm));
	alrm_host i_alrm_host (.sclk(sclk), .cs_b(cs_b), .sdi(sdi), .sdo(sdo));

	// 250 MHz system clock
	always #2 clk = ~clk;

	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// a complete frame executes, so its upper byte becomes the next echo
	task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d, input int n);
		i_alrm_host.frame({a, w, d}, n, r);
		if (n >= 16)
			echo = {a, w};
	endtask

	task automatic rdchk(input logic [6:0] a, input int exp);
		xfer(a, 1'b0, 8'h00, 25);
		chk(r, {exp[7:0], 1'b0});
	endtask

	// the model flag only moves while ce is high, since ce low freezes the bank
	task automatic alarm(input int c, input int code);
		logic [11:0] k;
		k = code[11:0];
		@(negedge clk);
		result_valid = 1'b1;
		result = {c[2:0], k};
		@(negedge clk);
		result_valid = 1'b0;
		if (ce)
			al[c] = int'(k) < lim[c];
		@(negedge clk);
		chk({8'h00, low_alarm[c]}, 9'(al[c]));
	endtask

	// reset pulse of two cycles; the model clears together with the design
	task automatic pulse_reset;
		rst_b = 1'b0;
		echo = 0;
		foreach (lim[c]) begin
			lim[c] = 0;
			al[c]  = 0;
		end
		repeat (2) @(negedge clk);
		chk({1'b0, low_alarm}, 9'h000);
		rst_b = 1'b1;
		repeat (8) @(negedge clk);
	endtask

	task automatic results;
		if (num_errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// watchdog well past the expected run of about 45 us
	initial begin
		#150000;
		num_errors++;
		results;
	end

	// main sequence
	initial begin
		void'($urandom(32'h1786e03b));
		clk = 1'b0;
		ce = 1'b1;
		result_valid = 1'b0;
		result = '0;
		pulse_reset;
		rdchk(7'h3f, 0);
		rdchk(7'h18, 0);
		for (int c = 0; c < 8; c++) begin
			lim[c] = $urandom_range(4095);
			xfer(7'h18 + 7'(5 * c), 1'b1, 8'(lim[c] >> 4), 16);
			xfer(7'h19 + 7'(5 * c), 1'b1, {lim[c][3:0], 4'($urandom)}, 16);
			rdchk(7'h3f, echo);
			rdchk(7'h18 + 7'(5 * c), lim[c] >> 4);
			rdchk(7'h19 + 7'(5 * c), (lim[c] % 16) * 16);
			alarm(c, lim[c] - 1);
			alarm(c, lim[c]);
			alarm(c, $urandom_range(4095));
		end
		// ce low holds the flag through a result pulse that would clear it
		alarm(0, 0);
		ce = 1'b0;
		alarm(0, 4095);
		ce = 1'b1;
		// refused writes in full frames still leave their upper byte in the echo; a cut-short frame leaves none
		xfer(7'h3f, 1'b1, 8'h5a, 16);
		rdchk(7'h3f, 8'h7f);
		xfer(7'h18, 1'b1, 8'h00, 8);
		rdchk(7'h3f, echo);
		rdchk(7'h18, lim[0] >> 4);
		xfer(7'h02, 1'b1, 8'hff, 16);
		rdchk(7'h02, 0);
		e = echo;
		xfer(7'h3f, 1'b0, 8'h00, 24);
		chk(r, {e[7:0], 1'b0});
		rdchk(7'h3f, 8'h7e);
		// a second reset in mid-run clears limits, echo and flags again
		@(negedge clk);
		pulse_reset;
		rdchk(7'h3f, 0);
		rdchk(7'h1d, 0);
		rdchk(7'h19, 0);
		alarm(1, 0);
		results;
	end
endmodule
`default_nettype wire

// >>> design/alrm_defines.svh
// Purpose: offsets, field positions, reset values and frame counts of the low-limit bank
// Assumes: 7-bit register addresses carried in the upper bits of a 16-bit frame word
// Notes: definitions only
`ifndef ALRM_DEFINES_SVH
`define ALRM_DEFINES_SVH

`define ALRM_LOW_MSB_OFS  7'h18
`define ALRM_LOW_LSB_OFS  7'h19
`define ALRM_CH_STRIDE    7'h05
`define ALRM_ECHO_OFS     7'h3f
`define ALRM_NIB_HI       7
`define ALRM_NIB_LO       4
`define ALRM_HI_RST       8'h00
`define ALRM_LO_RST       4'h0
`define ALRM_ECHO_RST     8'h00
`define ALRM_WORD_LAST    5'd15
`define ALRM_OUT_FIRST    5'd16
`define ALRM_OUT_END      5'd24

`endif

// >>> design/alrm_pkg.sv
// Purpose: types shared by the low-limit bank
// Assumes: up to eight channels, 12-bit conversion codes
// Notes: frame word is address, write flag, data
package alrm_pkg;

	typedef struct packed {
		logic [6:0] addr;
		logic       wr;
		logic [7:0] data;
	} alrm_cmd_t;

	typedef struct packed {
		logic [2:0]  ch;
		logic [11:0] code;
	} alrm_result_t;

endpackage

// >>> design/alrm_regs.sv
// Purpose: per-channel low alarm limits and command echo behind the serial frame port
// Assumes: host drives sclk and cs_b; sdi sampled on rising, sdo changed on falling sclk
// Notes: registers live on clk; a frozen snapshot feeds the serial side while a frame runs
// Notes on behaviour
// - each channel has a read-write byte holding limit bits 11:4; channel 0 at 18h.
// - companion register bits 7:4 hold limit bits 3:0; channel 0 at 19h.
// - companion register bits 3:0 always read zero, writes ignored.
// - the 12-bit limit is upper byte then companion nibble.
// - read-back at 3Fh returns the command executed in the previous frame.
// - echo leaves sdo msb first from the sixteenth falling sclk edge.
// - echo carries command bits 15:8 then zero bits to the end of the frame.
`timescale 1ns/100ps
`default_nettype none
`include "alrm_defines.svh"

module alrm_regs import alrm_pkg::*; #(
	parameter int N_CH = 8
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         ce,
	input  wire logic         sclk,
	input  wire logic         cs_b,
	input  wire logic         sdi,
	input  wire logic         result_valid,
	input  wire alrm_result_t result,
	output var  logic         sdo,
	output var  logic [N_CH-1:0] low_alarm
);

	// returns {hit, channel} when addr is base plus 0 to N_CH-1 strides
	function automatic logic [3:0] slot_of(input logic [6:0] a, input logic [6:0] base);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < N_CH; i++) begin
			if (a == 7'(base + 7'(i) * `ALRM_CH_STRIDE)) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction

	// ---------------- link side, on sclk ----------------
	logic       link_rst_b;
	logic [4:0] cnt;
	logic [14:0] shift;
	alrm_cmd_t  word;
	logic       word_tgl;
	logic [7:0] rd_byte;
	logic [3:0] rd_hi;
	logic [3:0] rd_lo;

	// clk-side state, published to the link while no frame runs
	logic [7:0] lim_hi [N_CH];
	logic [3:0] lim_lo [N_CH];
	logic [7:0] echo;
	logic [7:0] pub_hi [N_CH];
	logic [3:0] pub_lo [N_CH];
	logic [7:0] pub_echo;

	// the frame select ends all link state; nothing on sclk outlives a frame but word and word_tgl
	assign link_rst_b = rst_b & cs_b ? 1'b0 : rst_b;

	// bit counter and input shifter; counter parks at 24 since later bits carry nothing
	always_ff @(posedge sclk or negedge link_rst_b) begin
		if (!link_rst_b) begin
			cnt   <= 5'd0;
			shift <= 15'h0000;
		end else begin
			if (cnt != `ALRM_OUT_END) begin
				cnt <= cnt + 5'd1;
			end
			if (cnt <= `ALRM_WORD_LAST) begin
				shift <= {shift[13:0], sdi};
			end
		end
	end

	// whole word taken on the sixteenth rising edge; toggle tells the clk side
	always_ff @(posedge sclk or negedge rst_b) begin
		if (!rst_b) begin
			word     <= '0;
			word_tgl <= 1'b0;
		end else if (cnt == `ALRM_WORD_LAST) begin
			word     <= {shift, sdi};
			word_tgl <= ~word_tgl;
		end
	end

	assign rd_hi = slot_of(word.addr, `ALRM_LOW_MSB_OFS);
	assign rd_lo = slot_of(word.addr, `ALRM_LOW_LSB_OFS);

	// read data; pub_* are quasi-static because they only move while cs_b is high
	always_comb begin
		rd_byte = 8'h00;
		if (word.addr == `ALRM_ECHO_OFS) begin
			rd_byte = pub_echo;
		end else if (rd_hi[3]) begin
			rd_byte = pub_hi[rd_hi[2:0]];
		end else if (rd_lo[3]) begin
			rd_byte = {pub_lo[rd_lo[2:0]], 4'h0};
		end
	end

	// serial output from the sixteenth falling edge, msb first, zero after eight bits
	always_ff @(negedge sclk or negedge link_rst_b) begin
		if (!link_rst_b) begin
			sdo <= 1'b0;
		end else if (!word.wr && cnt >= `ALRM_OUT_FIRST && cnt < `ALRM_OUT_END) begin
			sdo <= rd_byte[3'(5'd23 - cnt)];
		end else begin
			sdo <= 1'b0;
		end
	end

	// ---------------- register side, on clk ----------------
	logic tgl_s;
	logic tgl_q;
	logic cs_idle;
	logic frame_done;
	logic any_frame;
	logic [3:0] wr_hi;
	logic [3:0] wr_lo;

	alrm_sync3 #(.INIT(1'b0)) u_tgl_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.ce    (ce),
		.d     (word_tgl),
		.q     (tgl_s)
	);

	alrm_sync3 #(.INIT(1'b1)) u_cs_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.ce    (ce),
		.d     (cs_b),
		.q     (cs_idle)
	);

	// word is stable for many clk cycles after its toggle, so it is read directly
	assign frame_done = tgl_s != tgl_q;
	assign wr_hi      = slot_of(word.addr, `ALRM_LOW_MSB_OFS);
	assign wr_lo      = slot_of(word.addr, `ALRM_LOW_LSB_OFS);

	// executes each finished frame: register writes and the command echo
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tgl_q     <= 1'b0;
			echo      <= `ALRM_ECHO_RST;
			any_frame <= 1'b0;
			for (int i = 0; i < N_CH; i++) begin
				lim_hi[i] <= `ALRM_HI_RST;
				lim_lo[i] <= `ALRM_LO_RST;
			end
		end else if (ce) begin
			tgl_q <= tgl_s;
			if (frame_done) begin
				echo      <= word[15:8];
				any_frame <= 1'b1;
				if (word.wr && wr_hi[3]) begin
					lim_hi[wr_hi[2:0]] <= word.data;
				end
				if (word.wr && wr_lo[3]) begin
					lim_lo[wr_lo[2:0]] <= word.data[`ALRM_NIB_HI:`ALRM_NIB_LO];
				end
			end
		end
	end

	// snapshot for the link, refreshed only between frames
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pub_echo <= `ALRM_ECHO_RST;
			for (int i = 0; i < N_CH; i++) begin
				pub_hi[i] <= `ALRM_HI_RST;
				pub_lo[i] <= `ALRM_LO_RST;
			end
		end else if (ce && cs_idle) begin
			pub_echo <= echo;
			for (int i = 0; i < N_CH; i++) begin
				pub_hi[i] <= lim_hi[i];
				pub_lo[i] <= lim_lo[i];
			end
		end
	end

	// low alarm compare against the concatenated limit
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			low_alarm <= '0;
		end else if (ce && result_valid && int'(result.ch) < N_CH) begin
			low_alarm[result.ch] <= result.code < {lim_hi[result.ch], lim_lo[result.ch]};
		end
	end

	// ---------------- checks ----------------
	upper_write_a: assert property (@(posedge clk) disable iff (!rst_b)
		(ce && frame_done && word.wr && word.addr == 7'h18)
		|=> lim_hi[0] == $past(word.data))
		else $error("upper limit byte not written");

	lower_write_a: assert property (@(posedge clk) disable iff (!rst_b)
		(ce && frame_done && word.wr && word.addr == 7'h19)
		|=> lim_lo[0] == $past(word.data[7:4]))
		else $error("lower limit nibble not written");

	lower_nibble_zero_a: assert property (@(negedge sclk) disable iff (!link_rst_b)
		(cnt >= 5'd20 && cnt <= 5'd23 && !word.wr && word.addr == 7'h19) |=> !sdo)
		else $error("lower limit low nibble not zero");

	limit_equal_a: assert property (@(posedge clk) disable iff (!rst_b)
		(ce && result_valid && result.ch == 3'h0 && result.code == {lim_hi[0], lim_lo[0]})
		|=> !low_alarm[0])
		else $error("alarm set at limit");

	echo_capture_a: assert property (@(posedge clk) disable iff (!rst_b)
		(ce && frame_done) |=> echo == $past(word[15:8]) ##1 1'b1)
		else $error("echo not captured");

	echo_msb_first_a: assert property (@(negedge sclk) disable iff (!link_rst_b)
		(cnt == 5'd16 && !word.wr && word.addr == 7'h3f) |=> sdo == $past(pub_echo[7]))
		else $error("echo msb not first");

	echo_tail_zero_a: assert property (@(negedge sclk) disable iff (!link_rst_b)
		(cnt == 5'd24) |=> !sdo [*2])
		else $error("echo tail not zero");

	reset_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
		!any_frame |-> (echo == 8'h00 && lim_hi[0] == 8'h00 && lim_lo[0] == 4'h0))
		else $error("state not clear before first frame");

	alarm_below_a: assert property (@(posedge clk) disable iff (!rst_b)
		(ce && result_valid && result.ch == 3'h0 && result.code < {lim_hi[0], lim_lo[0]})
		|=> low_alarm[0])
		else $error("alarm missed below limit");

endmodule

`default_nettype wire

// >>> design/alrm_sync3.sv
// Purpose: three-stage synchroniser for a level from another clock domain
// Assumes: the source level holds for several destination cycles
// Notes: output follows only once the second and third stages agree
`timescale 1ns/100ps
`default_nettype none

module alrm_sync3 #(
	parameter logic INIT = 1'b0
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic ce,
	input  wire logic d,
	output var  logic q
);

	logic s1;
	logic s2;
	logic s3;

	// the first stage feeds only the second; the agree test filters a late settle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
			q  <= INIT;
		end else if (ce) begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				q <= s3;
			end
		end
	end

endmodule

`default_nettype wire
